/* File: src/gpbd_bridge_decode.sv */
// Address routing, configuration registers and error control of the graphics port bridge
//
// How it works
// - Memory inside prefetchable base..limit, bits 31:20 compared, goes to graphics port.
// - Base comparison takes the low twenty address bits as zero.
// - Limit comparison takes the low twenty address bits as all ones.
// - Prefetch base/limit: only upper twelve bits writable, low four read zero.
// - Reset: prefetch base fff0, limit 0000, so no window decodes.
// - Back-to-back enable bit reads zero and ignores writes.
// - Secondary bus reset bit reads zero; never resets the port.
// - Master abort: drop write data, return all ones on read; mode reads zero.
// - VGA routing set: memory 0a0000-0bffff goes to graphics port.
// - VGA routing set: I/O 3b0-3bb, 3c0-3df on low ten bits, aliases match.
// - VGA forwarding ignores base/limit windows and the ISA filter.
// - VGA routing clear by reset: legacy ranges go to hub unless windowed.
// - ISA filter set: windowed I/O in last 768 bytes per KB goes to hub.
// - ISA filter clear: every I/O cycle inside the window goes to port.
// - Parity response and system-error enable: port parity error sends hub SERR.
// - Parity response clear: no SERR for parity; other errors still signal.
// - No parity error pin on the port; reporting only through hub messages.
// - Target abort report bit plus global enable: SERR per received target abort.
// - I/O inside base..limit on bits 15:12 goes to graphics port.
// - Non-prefetchable window also forwards memory with 1-MB granularity.
`timescale 1ns/10ps

module gpbd_bridge_decode (
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cfg_wr,
	input  wire logic        i_cfg_rd,
	input  wire logic [7:0]  i_cfg_addr,
	input  wire logic [7:0]  i_cfg_wdata,
	input  wire logic        i_device_system_error_enable,
	input  wire logic        i_req_valid,
	input  wire logic        i_req_is_io,
	input  wire logic [31:0] i_req_addr,
	input  wire logic        i_port_master_abort,
	input  wire logic        i_port_master_abort_read,
	input  wire logic        i_port_parity_error,
	input  wire logic        i_port_target_abort,
	input  wire logic        i_other_error,
	output logic      [7:0]  o_cfg_rdata,
	output logic             o_cfg_rvalid,
	output logic             o_route_valid,
	output logic             o_route_to_port,
	output logic             o_abort_rdata_valid,
	output logic      [31:0] o_abort_rdata,
	output logic             o_abort_write_dropped,
	output logic             o_serr_msg
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0]  io_base_q,  io_base_d;
	logic [7:0]  io_limit_q, io_limit_d;
	logic [15:0] np_base_q,  np_base_d;
	logic [15:0] np_limit_q, np_limit_d;
	logic [15:0] pf_base_q,  pf_base_d;
	logic [15:0] pf_limit_q, pf_limit_d;
	logic [7:0]  bctrl_q,    bctrl_d;
	logic [7:0]  errcmd_q,   errcmd_d;
	logic [7:0]  cfg_rdata_q, cfg_rdata_d;
	logic        cfg_rvalid_q, cfg_rvalid_d;

	// Byte-wide writes; masks keep fixed bits at their reset zero
	always_comb begin
		io_base_d   = io_base_q;
		io_limit_d  = io_limit_q;
		np_base_d   = np_base_q;
		np_limit_d  = np_limit_q;
		pf_base_d   = pf_base_q;
		pf_limit_d  = pf_limit_q;
		bctrl_d     = bctrl_q;
		errcmd_d    = errcmd_q;
		if (i_cfg_wr) begin
			case (i_cfg_addr)
				gpbd_pkg::OFF_IO_BASE:      io_base_d  = i_cfg_wdata & gpbd_pkg::IO_WMASK;
				gpbd_pkg::OFF_IO_LIMIT:     io_limit_d = i_cfg_wdata & gpbd_pkg::IO_WMASK;
				gpbd_pkg::OFF_NP_BASE:      np_base_d[7:0]   = i_cfg_wdata & gpbd_pkg::WIN_WMASK[7:0];
				8'(gpbd_pkg::OFF_NP_BASE + 1):  np_base_d[15:8]  = i_cfg_wdata;
				gpbd_pkg::OFF_NP_LIMIT:     np_limit_d[7:0]  = i_cfg_wdata & gpbd_pkg::WIN_WMASK[7:0];
				8'(gpbd_pkg::OFF_NP_LIMIT + 1): np_limit_d[15:8] = i_cfg_wdata;
				gpbd_pkg::OFF_PF_BASE:      pf_base_d[7:0]   = i_cfg_wdata & gpbd_pkg::WIN_WMASK[7:0];
				8'(gpbd_pkg::OFF_PF_BASE + 1):  pf_base_d[15:8]  = i_cfg_wdata;
				gpbd_pkg::OFF_PF_LIMIT:     pf_limit_d[7:0]  = i_cfg_wdata & gpbd_pkg::WIN_WMASK[7:0];
				8'(gpbd_pkg::OFF_PF_LIMIT + 1): pf_limit_d[15:8] = i_cfg_wdata;
				// Bits 7:5 are hardwired zero, so writes there are lost
				gpbd_pkg::OFF_BCTRL:        bctrl_d  = i_cfg_wdata & gpbd_pkg::BCTRL_WMASK;
				gpbd_pkg::OFF_ERRCMD:       errcmd_d = i_cfg_wdata & gpbd_pkg::ERRCMD_WMASK;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped offsets return zero
	always_comb begin
		cfg_rvalid_d = i_cfg_rd;
		cfg_rdata_d  = 8'h00;
		if (i_cfg_rd) begin
			case (i_cfg_addr)
				gpbd_pkg::OFF_IO_BASE:      cfg_rdata_d = io_base_q;
				gpbd_pkg::OFF_IO_LIMIT:     cfg_rdata_d = io_limit_q;
				gpbd_pkg::OFF_NP_BASE:      cfg_rdata_d = np_base_q[7:0];
				8'(gpbd_pkg::OFF_NP_BASE + 1):  cfg_rdata_d = np_base_q[15:8];
				gpbd_pkg::OFF_NP_LIMIT:     cfg_rdata_d = np_limit_q[7:0];
				8'(gpbd_pkg::OFF_NP_LIMIT + 1): cfg_rdata_d = np_limit_q[15:8];
				gpbd_pkg::OFF_PF_BASE:      cfg_rdata_d = pf_base_q[7:0];
				8'(gpbd_pkg::OFF_PF_BASE + 1):  cfg_rdata_d = pf_base_q[15:8];
				gpbd_pkg::OFF_PF_LIMIT:     cfg_rdata_d = pf_limit_q[7:0];
				8'(gpbd_pkg::OFF_PF_LIMIT + 1): cfg_rdata_d = pf_limit_q[15:8];
				gpbd_pkg::OFF_BCTRL:        cfg_rdata_d = bctrl_q;
				gpbd_pkg::OFF_ERRCMD:       cfg_rdata_d = errcmd_q;
				default:                    cfg_rdata_d = 8'h00;
			endcase
		end
	end

	// Windows start closed: base above limit until software writes both
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			io_base_q    <= gpbd_pkg::RST_IO_BASE;
			io_limit_q   <= gpbd_pkg::RST_IO_LIMIT;
			np_base_q    <= gpbd_pkg::RST_WIN_BASE;
			np_limit_q   <= gpbd_pkg::RST_WIN_LIMIT;
			pf_base_q    <= gpbd_pkg::RST_WIN_BASE;
			pf_limit_q   <= gpbd_pkg::RST_WIN_LIMIT;
			bctrl_q      <= gpbd_pkg::RST_BCTRL;
			errcmd_q     <= gpbd_pkg::RST_ERRCMD;
			cfg_rdata_q  <= 8'h00;
			cfg_rvalid_q <= 1'b0;
		end else begin
			io_base_q    <= io_base_d;
			io_limit_q   <= io_limit_d;
			np_base_q    <= np_base_d;
			np_limit_q   <= np_limit_d;
			pf_base_q    <= pf_base_d;
			pf_limit_q   <= pf_limit_d;
			bctrl_q      <= bctrl_d;
			errcmd_q     <= errcmd_d;
			cfg_rdata_q  <= cfg_rdata_d;
			cfg_rvalid_q <= cfg_rvalid_d;
		end
	end

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	logic vga_on, isa_on;
	logic pf_hit, np_hit, io_hit, isa_tail, vga_mem_hit, vga_io_hit;
	logic route_valid_q, route_valid_d;
	logic route_port_q, route_port_d;

	assign vga_on = bctrl_q[gpbd_pkg::BC_VGA_ROUTE];
	assign isa_on = bctrl_q[gpbd_pkg::BC_ISA_FILTER];

	// Window bounds widened with zero / all-ones low bits
	assign pf_hit = (i_req_addr >= {pf_base_q[15:4], gpbd_pkg::MEM_LOW_ZERO}) &&
		(i_req_addr <= {pf_limit_q[15:4], gpbd_pkg::MEM_LOW_ONES});
	assign np_hit = (i_req_addr >= {np_base_q[15:4], gpbd_pkg::MEM_LOW_ZERO}) &&
		(i_req_addr <= {np_limit_q[15:4], gpbd_pkg::MEM_LOW_ONES});
	assign io_hit = (i_req_addr[15:0] >= {io_base_q[7:4], gpbd_pkg::IO_LOW_ZERO}) &&
		(i_req_addr[15:0] <= {io_limit_q[7:4], gpbd_pkg::IO_LOW_ONES});
	// Only the first 256 bytes of each KB are true I/O; the rest aliases ISA
	assign isa_tail = (i_req_addr[9:0] >= gpbd_pkg::ISA_TAIL_LO);
	assign vga_mem_hit = (i_req_addr >= gpbd_pkg::VGA_MEM_LO) &&
		(i_req_addr <= gpbd_pkg::VGA_MEM_HI);
	// Bits 15:10 are not looked at, so every alias matches
	assign vga_io_hit = ((i_req_addr[9:0] >= gpbd_pkg::VGA_IO_A_LO) &&
		(i_req_addr[9:0] <= gpbd_pkg::VGA_IO_A_HI)) ||
		((i_req_addr[9:0] >= gpbd_pkg::VGA_IO_B_LO) &&
		(i_req_addr[9:0] <= gpbd_pkg::VGA_IO_B_HI));

	// VGA term is ORed outside the window/filter terms so it overrides them
	always_comb begin
		route_valid_d = i_req_valid;
		route_port_d  = 1'b0;
		if (i_req_valid) begin
			if (i_req_is_io) begin
				route_port_d = (vga_on && vga_io_hit) ||
					(io_hit && !(isa_on && isa_tail));
			end else begin
				route_port_d = (vga_on && vga_mem_hit) || pf_hit || np_hit;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			route_valid_q <= 1'b0;
			route_port_q  <= 1'b0;
		end else begin
			route_valid_q <= route_valid_d;
			route_port_q  <= route_port_d;
		end
	end

	// ----------------------------------------------------------------
	// Master abort completion and error messaging
	// ----------------------------------------------------------------
	logic        ab_rvalid_q, ab_rvalid_d;
	logic [31:0] ab_rdata_q, ab_rdata_d;
	logic        ab_wdrop_q, ab_wdrop_d;
	logic        serr_q, serr_d;

	// Parity is reported only as a hub message; no pin exists for it
	always_comb begin
		ab_rvalid_d = i_port_master_abort && i_port_master_abort_read;
		ab_wdrop_d  = i_port_master_abort && !i_port_master_abort_read;
		ab_rdata_d  = ab_rvalid_d ? gpbd_pkg::ABORT_RDATA : 32'h00000000;
		serr_d      = i_device_system_error_enable && (
			(bctrl_q[gpbd_pkg::BC_PARITY_RESP] && i_port_parity_error) ||
			(errcmd_q[gpbd_pkg::EC_TA_REPORT] && i_port_target_abort) ||
			i_other_error);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ab_rvalid_q <= 1'b0;
			ab_rdata_q  <= 32'h00000000;
			ab_wdrop_q  <= 1'b0;
			serr_q      <= 1'b0;
		end else begin
			ab_rvalid_q <= ab_rvalid_d;
			ab_rdata_q  <= ab_rdata_d;
			ab_wdrop_q  <= ab_wdrop_d;
			serr_q      <= serr_d;
		end
	end

	// Outputs, all from flip-flops
	assign o_cfg_rdata           = cfg_rdata_q;
	assign o_cfg_rvalid          = cfg_rvalid_q;
	assign o_route_valid         = route_valid_q;
	assign o_route_to_port       = route_port_q;
	assign o_abort_rdata_valid   = ab_rvalid_q;
	assign o_abort_rdata         = ab_rdata_q;
	assign o_abort_write_dropped = ab_wdrop_q;
	assign o_serr_msg            = serr_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	sequence s_pf_write_low;
		i_cfg_wr && (i_cfg_addr == gpbd_pkg::OFF_PF_BASE);
	endsequence
	sequence s_read_back_pf;
		##1 i_cfg_rd && (i_cfg_addr == gpbd_pkg::OFF_PF_BASE) ##1 o_cfg_rvalid;
	endsequence

	chk_pref_low_zero: assert property (
		s_pf_write_low ##0 s_read_back_pf |-> o_cfg_rdata[3:0] == 4'h0)
		else $error("prefetch base low nibble not zero");

	chk_bctrl_fixed_bits: assert property (
		i_cfg_rd && (i_cfg_addr == gpbd_pkg::OFF_BCTRL) |=> o_cfg_rdata[7:5] == 3'b000)
		else $error("bridge control fixed bits read nonzero");

	chk_pref_window_hit: assert property (
		i_req_valid && !i_req_is_io && (i_req_addr[31:20] >= pf_base_q[15:4]) &&
		(i_req_addr[31:20] <= pf_limit_q[15:4]) |=> o_route_valid && o_route_to_port)
		else $error("prefetch window access not sent to port");

	chk_vga_mem_route: assert property (
		i_req_valid && !i_req_is_io && vga_on && (i_req_addr[31:17] == 15'h0005)
		|=> o_route_to_port)
		else $error("vga memory access not sent to port");

	chk_vga_io_alias: assert property (
		i_req_valid && i_req_is_io && vga_on && isa_on && (i_req_addr[9:0] == 10'h3d4)
		|=> o_route_to_port)
		else $error("vga io alias not sent to port");

	chk_isa_tail_hub: assert property (
		i_req_valid && i_req_is_io && !vga_on && isa_on && (i_req_addr[9:8] != 2'b00)
		|=> o_route_valid && !o_route_to_port)
		else $error("isa alias tail not sent to hub");

	chk_unmatched_hub: assert property (
		i_req_valid && !i_req_is_io && !pf_hit && !np_hit && !(vga_on && vga_mem_hit)
		|=> !o_route_to_port)
		else $error("unmatched memory access not sent to hub");

	chk_abort_read_ones: assert property (
		i_port_master_abort && i_port_master_abort_read
		|=> o_abort_rdata_valid && (o_abort_rdata == 32'hffffffff) && !o_abort_write_dropped)
		else $error("master abort read did not return all ones");

	chk_parity_serr: assert property (
		i_port_parity_error && bctrl_q[gpbd_pkg::BC_PARITY_RESP] &&
		i_device_system_error_enable |=> o_serr_msg)
		else $error("enabled parity error gave no serr");

	chk_parity_quiet: assert property (
		i_port_parity_error && !bctrl_q[gpbd_pkg::BC_PARITY_RESP] && !i_port_target_abort &&
		!i_other_error |=> !o_serr_msg)
		else $error("disabled parity error gave serr");

	chk_target_abort_serr: assert property (
		i_port_target_abort && !i_port_parity_error && !i_other_error
		|=> o_serr_msg == ($past(errcmd_q[gpbd_pkg::EC_TA_REPORT]) &&
		$past(i_device_system_error_enable)))
		else $error("target abort serr mismatch");

endmodule

/* File: pkg/gpbd_pkg.sv */
// Constants shared by the graphics port bridge decode block
package gpbd_pkg;

	// ----------------------------------------------------------------
	// Configuration offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_IO_BASE   = 8'h1c;
	localparam logic [7:0] OFF_IO_LIMIT  = 8'h1d;
	localparam logic [7:0] OFF_NP_BASE   = 8'h20;
	localparam logic [7:0] OFF_NP_LIMIT  = 8'h22;
	localparam logic [7:0] OFF_PF_BASE   = 8'h24;
	localparam logic [7:0] OFF_PF_LIMIT  = 8'h26;
	localparam logic [7:0] OFF_BCTRL     = 8'h3e;
	localparam logic [7:0] OFF_ERRCMD    = 8'h40;

	// ----------------------------------------------------------------
	// Reset values and writable-bit masks
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_IO_BASE   = 8'hf0;
	localparam logic [7:0]  RST_IO_LIMIT  = 8'h00;
	localparam logic [15:0] RST_WIN_BASE  = 16'hfff0;
	localparam logic [15:0] RST_WIN_LIMIT = 16'h0000;
	localparam logic [7:0]  RST_BCTRL     = 8'h00;
	localparam logic [7:0]  RST_ERRCMD    = 8'h00;
	localparam logic [7:0]  IO_WMASK      = 8'hf0;
	localparam logic [15:0] WIN_WMASK     = 16'hfff0;
	localparam logic [7:0]  BCTRL_WMASK   = 8'h0d;
	localparam logic [7:0]  ERRCMD_WMASK  = 8'h01;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BC_PARITY_RESP = 0;
	localparam int BC_ISA_FILTER  = 2;
	localparam int BC_VGA_ROUTE   = 3;
	localparam int BC_MA_MODE     = 5;
	localparam int BC_SEC_RESET   = 6;
	localparam int BC_BACK_TO_BACK = 7;
	localparam int EC_TA_REPORT   = 0;

	// ----------------------------------------------------------------
	// Legacy ranges and fixed data
	// ----------------------------------------------------------------
	localparam logic [31:0] VGA_MEM_LO    = 32'h000a0000;
	localparam logic [31:0] VGA_MEM_HI    = 32'h000bffff;
	localparam logic [9:0]  VGA_IO_A_LO   = 10'h3b0;
	localparam logic [9:0]  VGA_IO_A_HI   = 10'h3bb;
	localparam logic [9:0]  VGA_IO_B_LO   = 10'h3c0;
	localparam logic [9:0]  VGA_IO_B_HI   = 10'h3df;
	localparam logic [9:0]  ISA_TAIL_LO   = 10'h100;
	localparam logic [19:0] MEM_LOW_ZERO  = 20'h00000;
	localparam logic [19:0] MEM_LOW_ONES  = 20'hfffff;
	localparam logic [11:0] IO_LOW_ZERO   = 12'h000;
	localparam logic [11:0] IO_LOW_ONES   = 12'hfff;
	localparam logic [31:0] ABORT_RDATA   = 32'hffffffff;

endpackage

/* File: verification/gpbd_far_side.sv */
// Far-side model: graphics port target and hub error sources
`timescale 1ns/10ps

module gpbd_far_side (
	input  wire logic i_mclk,
	output logic      o_master_abort,
	output logic      o_master_abort_read,
	output logic      o_parity_error,
	output logic      o_target_abort,
	output logic      o_other_error
);
	// ----------------------------------------------------------------
	// Event pulses
	// ----------------------------------------------------------------
	// Quiet at time zero so no event is seen during reset
	initial begin
		o_master_abort = 1'b0;
		o_master_abort_read = 1'b1;
		o_parity_error = 1'b0;
		o_target_abort = 1'b0;
		o_other_error = 1'b0;
	end

	// One event for one cycle after lag cycles; kind 0 abort, 1 parity, 2 target, 3 other
	task automatic send(input int kind, input int lag, input logic rd);
		begin
			repeat (lag) @(negedge i_mclk);
			o_master_abort_read = rd;
			o_master_abort = (kind == 0);
			o_parity_error = (kind == 1); // Event only, no pin of its own
			o_target_abort = (kind == 2);
			o_other_error = (kind == 3);
			@(negedge i_mclk);
			o_master_abort = 1'b0;
			o_parity_error = 1'b0;
			o_target_abort = 1'b0;
			o_other_error = 1'b0;
			// Qualifier is stale now, so show its inverse rather than hold it
			o_master_abort_read = ~rd;
		end
	endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking testbench of the graphics port bridge decode block
`timescale 1ns/10ps

module testbench;
	logic        i_mclk, i_rst_n, i_cfg_wr, i_cfg_rd, i_sys_en, i_req_valid, i_req_is_io;
	logic [7:0]  i_cfg_addr, i_cfg_wdata, o_cfg_rdata;
	logic [31:0] i_req_addr, o_abort_rdata;
	logic        ma, ma_rd, par, ta, oth, o_cfg_rvalid, o_route_valid, o_route_to_port;
	logic        o_abort_rdata_valid, o_abort_write_dropped, o_serr_msg;
	int          err_total, checked, cycles;

	gpbd_far_side u_far (.i_mclk(i_mclk), .o_master_abort(ma), .o_master_abort_read(ma_rd),
		.o_parity_error(par), .o_target_abort(ta), .o_other_error(oth));

	gpbd_bridge_decode u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cfg_wr(i_cfg_wr),
		.i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata),
		.i_device_system_error_enable(i_sys_en), .i_req_valid(i_req_valid),
		.i_req_is_io(i_req_is_io), .i_req_addr(i_req_addr), .i_port_master_abort(ma),
		.i_port_master_abort_read(ma_rd), .i_port_parity_error(par),
		.i_port_target_abort(ta), .i_other_error(oth), .o_cfg_rdata(o_cfg_rdata),
		.o_cfg_rvalid(o_cfg_rvalid), .o_route_valid(o_route_valid),
		.o_route_to_port(o_route_to_port), .o_abort_rdata_valid(o_abort_rdata_valid),
		.o_abort_rdata(o_abort_rdata), .o_abort_write_dropped(o_abort_write_dropped),
		.o_serr_msg(o_serr_msg));

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	// 40 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end

	// About 135 cycles are expected; far beyond that means a hang
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			err_total++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks, entered and left at a falling edge except finish_test, which the hang guard calls at a rising edge
	// ----------------------------------------------------------------
	task automatic chk(input bit ok, input string msg);
		checked++;
		if (!ok) begin
			err_total++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [7:0] d);
		i_cfg_wr = 1'b1;
		i_cfg_addr = a;
		i_cfg_wdata = d;
		@(negedge i_mclk);
		i_cfg_wr = 1'b0;
		i_cfg_wdata = ~d;
		// Idle cycle so the next call does not re-raise the strobe in this time step
		@(negedge i_mclk);
	endtask

	// Write, then read back at the very next edge; the read strobe takes over
	task automatic cfg_wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
		i_cfg_wr = 1'b1;
		i_cfg_addr = a;
		i_cfg_wdata = d;
		@(negedge i_mclk);
		i_cfg_wr = 1'b0;
		i_cfg_wdata = ~d;
		i_cfg_rd = 1'b1;
		@(negedge i_mclk);
		i_cfg_rd = 1'b0;
		chk(o_cfg_rvalid === 1'b1 && o_cfg_rdata === exp, $sformatf("readback %h", a));
		@(negedge i_mclk);
	endtask

	// Read answer stands one cycle only, so it is judged in that cycle
	task automatic cfg_rd(input logic [7:0] a, input logic [7:0] exp);
		i_cfg_rd = 1'b1;
		i_cfg_addr = a;
		@(negedge i_mclk);
		i_cfg_rd = 1'b0;
		chk(o_cfg_rvalid === 1'b1 && o_cfg_rdata === exp, $sformatf("read %h", a));
		@(negedge i_mclk);
	endtask

	task automatic route(input logic io, input logic [31:0] a, input logic exp);
		i_req_valid = 1'b1;
		i_req_is_io = io;
		i_req_addr = a;
		@(negedge i_mclk);
		i_req_valid = 1'b0;
		i_req_addr = ~a;
		chk(o_route_valid === 1'b1 && o_route_to_port === exp, $sformatf("route %h", a));
		@(negedge i_mclk);
	endtask

	task automatic err_ev(input int kind, input int lag, input logic rd, input logic exp);
		u_far.send(kind, lag, rd);
		chk(o_serr_msg === exp, $sformatf("serr kind %0d", kind));
		if (kind == 0)
			chk(o_abort_rdata_valid === rd && o_abort_write_dropped === !rd
				&& o_abort_rdata === (rd ? 32'hffffffff : 32'h00000000), "abort");
		// The model's pulses must not fall and rise again in one time step
		@(negedge i_mclk);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic test_regs();
		cfg_rd(8'h24, 8'hf0);
		cfg_rd(8'h25, 8'hff);
		cfg_rd(8'h26, 8'h00);
		cfg_rd(8'h27, 8'h00);
		cfg_rd(8'h3e, 8'h00);
		cfg_rd(8'h40, 8'h00);
		cfg_wr_rd(8'h3e, 8'hff, 8'h0d);
		cfg_wr_rd(8'h24, 8'hff, 8'hf0);
		cfg_wr_rd(8'h26, 8'h0f, 8'h00);
		cfg_wr_rd(8'h40, 8'hff, 8'h01);
		cfg_wr_rd(8'h50, 8'hff, 8'h00);
		$display("test regs done");
	endtask

	// Prefetch window 100h..10fh and non-prefetch window 200h, edges probed
	task automatic test_mem();
		cfg_wr(8'h3e, 8'h00);
		cfg_wr(8'h24, 8'h00);
		cfg_wr(8'h25, 8'h10);
		cfg_wr(8'h26, 8'hf0);
		cfg_wr(8'h27, 8'h10);
		route(1'b0, 32'h0fffffff, 1'b0);
		route(1'b0, 32'h10000000, 1'b1);
		route(1'b0, 32'h10ffffff, 1'b1);
		route(1'b0, 32'h11000000, 1'b0);
		cfg_wr(8'h20, 8'h00);
		cfg_wr(8'h21, 8'h20);
		cfg_wr(8'h23, 8'h20);
		route(1'b0, 32'h200fffff, 1'b1);
		route(1'b0, 32'h20100000, 1'b0);
		route(1'b0, 32'h000a0000, 1'b0);
		$display("test mem done");
	endtask

	// I/O window 0..fffh with filter and legacy routing both on
	task automatic test_vga();
		cfg_wr(8'h1c, 8'h00);
		cfg_wr(8'h1d, 8'h00);
		cfg_wr(8'h3e, 8'h0c);
		route(1'b0, 32'h000a0000, 1'b1);
		route(1'b0, 32'h000bffff, 1'b1);
		route(1'b0, 32'h000c0000, 1'b0);
		route(1'b1, 32'h000003b0, 1'b1);
		route(1'b1, 32'h000003bc, 1'b0);
		route(1'b1, 32'h0000c3df, 1'b1);
		route(1'b1, 32'h00000300, 1'b0);
		route(1'b1, 32'h000000ff, 1'b1);
		$display("test vga done");
	endtask

	// I/O window 1000h..2fffh, filter off then on
	task automatic test_io();
		cfg_wr(8'h3e, 8'h00);
		cfg_wr(8'h1c, 8'h10);
		cfg_wr(8'h1d, 8'h20);
		route(1'b1, 32'h00000fff, 1'b0);
		route(1'b1, 32'h00001000, 1'b1);
		route(1'b1, 32'h00002fff, 1'b1);
		route(1'b1, 32'h00003000, 1'b0);
		route(1'b0, 32'h00001000, 1'b0);
		cfg_wr(8'h3e, 8'h04);
		route(1'b1, 32'h00001300, 1'b0);
		route(1'b1, 32'h00001000, 1'b1);
		$display("test io done");
	endtask

	task automatic test_err();
		i_sys_en = 1'b1;
		cfg_wr(8'h3e, 8'h01);
		cfg_wr(8'h40, 8'h00);
		err_ev(1, 0, 1'b0, 1'b1);
		err_ev(0, 0, 1'b1, 1'b0);
		err_ev(0, 1, 1'b0, 1'b0);
		err_ev(2, 0, 1'b0, 1'b0);
		cfg_wr(8'h3e, 8'h00);
		err_ev(1, 0, 1'b0, 1'b0);
		err_ev(3, 0, 1'b0, 1'b1);
		cfg_wr(8'h40, 8'h01);
		err_ev(2, 2, 1'b0, 1'b1);
		i_sys_en = 1'b0;
		err_ev(2, 0, 1'b0, 1'b0);
		$display("test err done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{err_total, checked, cycles} = '0;
		{i_rst_n, i_cfg_wr, i_cfg_rd, i_sys_en, i_req_valid, i_req_is_io} = '0;
		{i_cfg_addr, i_cfg_wdata, i_req_addr} = '0;
		repeat (6) @(posedge i_mclk);
		@(negedge i_mclk);
		i_rst_n = 1'b1;
		@(negedge i_mclk);
		test_regs();
		test_mem();
		test_vga();
		test_io();
		test_err();
		finish_test();
	end
endmodule
